//--- src/sarrd_readout.v
// sarrd_readout.v: conversion control and serial readout of one channel
// assumes pins are asynchronous to ref_clk; shift clock much slower than ref_clk
`timescale 1ns/1ps
`include "sarrd_consts.vh"

module sarrd_readout #(
    parameter CONV_CYCLES = `SARRD_CONV_CYCLES
) (
    input  wire        ref_clk,              // system clock, 200 MHz
    input  wire        reset,                // sync reset, high
    input  wire        convert_start,        // convert-start pin
    input  wire        select_chain_input,   // select / chain input pin
    input  wire        serial_shift_clock,   // serial clock pin
    output wire        serial_result_out,    // serial output value
    output wire        serial_result_oe,     // serial output enable
    input  wire [15:0] sampleCode,           // code from the converter core
    output wire        sampleReady,          // core asked to sample
    output reg         convBusy,             // conversion running
    output reg         poweredDown,          // core powered down
    output reg         chainMode,            // latched mode, high = chain
    output reg         busyEnabled,          // latched busy indicator option
    output wire        resultValid,          // fifo holds a result
    input  wire        resultReady,          // sink takes a result
    output wire [15:0] resultData            // head result
);

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_CONV = 4'b0010;
    localparam [3:0] ST_RDY  = 4'b0100;
    localparam [3:0] ST_SHFT = 4'b1000;

    reg  [2:0]  cnvSync_ff;
    reg  [2:0]  selSync_ff;
    reg  [2:0]  sckSync_ff;
    wire        cnvLvl;
    wire        selLvl;
    wire        sckLvl;
    wire        cnvRise;
    wire        cnvFall;
    wire        selRise;
    wire        selFall;
    wire        sckFall;
    reg  [3:0]  state_ff;
    reg  [3:0]  nxt_state;
    reg  [`SARRD_CONV_CNT_W-1:0] convCnt_ff;
    reg         divTick_ff;
    reg  [15:0] shiftReg_ff;
    reg  [`SARRD_CNT_W-1:0] bitCnt_ff;
    reg         driveOn_ff;
    reg         outBit_ff;
    reg         startBit_ff;
    reg         convDone_ff;
    wire        fifoInReady;
    wire        lastFall;
    wire        releaseNow;
    wire        bothLow;

    // ------------------------------------------------------------------
    // pin synchronisers, two stages then an edge history stage
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (reset) begin
            cnvSync_ff <= 3'h0;
            selSync_ff <= 3'h0;
            sckSync_ff <= 3'h0;
        end else begin
            cnvSync_ff <= {cnvSync_ff[1:0], convert_start};
            selSync_ff <= {selSync_ff[1:0], select_chain_input};
            sckSync_ff <= {sckSync_ff[1:0], serial_shift_clock};
        end
    end

    assign cnvLvl  = cnvSync_ff[1];
    assign selLvl  = selSync_ff[1];
    assign sckLvl  = sckSync_ff[1];
    assign cnvRise = cnvSync_ff[1] && !cnvSync_ff[2];
    assign cnvFall = !cnvSync_ff[1] && cnvSync_ff[2];
    assign selRise = selSync_ff[1] && !selSync_ff[2];
    assign selFall = !selSync_ff[1] && selSync_ff[2];
    assign sckFall = !sckSync_ff[1] && sckSync_ff[2];

    // ------------------------------------------------------------------
    // conversion clock divider and state machine
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (reset) begin
            divTick_ff <= 1'b0;
        end else begin
            divTick_ff <= !divTick_ff; // conversion clock at half rate
        end
    end

    // next state
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (cnvRise) begin
                    nxt_state = ST_CONV;
                end
            end
            ST_CONV: begin
                // convert-start ignored while converting
                if (divTick_ff && convCnt_ff == 0) begin
                    nxt_state = ST_RDY;
                end
            end
            ST_RDY: begin
                // a new start wins over readout, as in the start branch below
                if (cnvRise) begin
                    nxt_state = ST_CONV;
                end else if (driveOn_ff) begin
                    nxt_state = ST_SHFT;
                end
            end
            ST_SHFT: begin
                // a start cuts a frame short, chain frames included
                if (cnvRise) begin
                    nxt_state = ST_CONV;
                end else if (!driveOn_ff) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // state, mode latch and conversion counter
    always @(posedge ref_clk) begin
        if (reset) begin
            state_ff    <= ST_IDLE;
            convCnt_ff  <= {`SARRD_CONV_CNT_W{1'b0}};
            chainMode   <= 1'b0;
            busyEnabled <= 1'b0;
            convBusy    <= 1'b0;
            poweredDown <= 1'b1;
            convDone_ff <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            convDone_ff <= 1'b0;
            if (cnvRise && state_ff != ST_CONV) begin
                // select level seen with convert-start; tied pins read low
                chainMode   <= !selSync_ff[2];
                busyEnabled <= !selSync_ff[2] && sckLvl;
                convCnt_ff  <= CONV_CYCLES[`SARRD_CONV_CNT_W-1:0];
                convBusy    <= 1'b1;
                poweredDown <= 1'b0;
            end else if (state_ff == ST_CONV && divTick_ff) begin
                if (convCnt_ff == 0) begin
                    convBusy    <= 1'b0;
                    poweredDown <= 1'b1;
                    convDone_ff <= 1'b1;
                    if (!chainMode) begin
                        busyEnabled <= !cnvLvl || !selLvl;
                    end
                end else begin
                    convCnt_ff <= convCnt_ff - 1'b1;
                end
            end
        end
    end

    assign sampleReady = cnvRise && state_ff != ST_CONV;

    // ------------------------------------------------------------------
    // output shifter
    // ------------------------------------------------------------------
    assign lastFall = startBit_ff ? (bitCnt_ff == `SARRD_LAST_BUSY - 1'b1)
                                  : (bitCnt_ff == `SARRD_LAST_PLAIN - 1'b1);
    assign releaseNow = !chainMode && (cnvRise || selRise);

    always @(posedge ref_clk) begin
        if (reset) begin
            shiftReg_ff <= `SARRD_RST_WORD;
            bitCnt_ff   <= {`SARRD_CNT_W{1'b0}};
            driveOn_ff  <= 1'b0;
            outBit_ff   <= 1'b0;
            startBit_ff <= 1'b0;
        end else if (cnvRise && state_ff != ST_CONV) begin
            driveOn_ff <= 1'b0;
            bitCnt_ff  <= {`SARRD_CNT_W{1'b0}};
        end else if (convDone_ff) begin
            shiftReg_ff <= sampleCode;
            bitCnt_ff   <= {`SARRD_CNT_W{1'b0}};
            startBit_ff <= busyEnabled;
            if (busyEnabled) begin
                driveOn_ff <= 1'b1;
                outBit_ff  <= chainMode;                        // start bit
            end else if (chainMode || (!cnvLvl || !selLvl)) begin
                driveOn_ff <= 1'b1;
                outBit_ff  <= sampleCode[15];
            end
        end else if (state_ff == ST_RDY && !driveOn_ff && (cnvFall || selFall)) begin
            driveOn_ff <= 1'b1;
            outBit_ff  <= shiftReg_ff[15];
        end else if (driveOn_ff && releaseNow) begin
            driveOn_ff <= 1'b0;
        end else if (driveOn_ff && sckFall) begin
            // bit held between falls, valid on both edges
            if (startBit_ff && bitCnt_ff == 0) begin
                outBit_ff <= shiftReg_ff[15];
            end else begin
                outBit_ff   <= shiftReg_ff[14];
                shiftReg_ff <= {shiftReg_ff[14:0], chainMode ? selLvl : 1'b0};
            end
            bitCnt_ff <= bitCnt_ff + 1'b1;
            if (lastFall && !chainMode) begin
                driveOn_ff <= 1'b0;
            end
        end
    end

    // pad: both pins low forces a driven low outside conversion
    assign bothLow           = !selLvl && !cnvLvl;
    assign serial_result_oe  = driveOn_ff || (bothLow && state_ff != ST_CONV);
    assign serial_result_out = (driveOn_ff && !bothLow) ? outBit_ff : 1'b0;

    // ------------------------------------------------------------------
    // result fifo
    // ------------------------------------------------------------------
    sarrd_fifo #(
        .WIDTH (`SARRD_RES_BITS),
        .DEPTH (`SARRD_FIFO_DEPTH),
        .AW    (`SARRD_FIFO_AW)
    ) u_fifo (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .inValid  (convDone_ff),
        .inReady  (fifoInReady),
        .inData   (sampleCode),
        .outValid (resultValid),
        .outReady (resultReady),
        .outData  (resultData)
    );

endmodule // sarrd_readout

//--- src/sarrd_consts.vh
// sarrd_consts.vh: shared constants of the serial readout controller
// assumes inclusion by bare name from the design files under src/
`ifndef SARRD_CONSTS_VH
`define SARRD_CONSTS_VH

// ------------------------------------------------------------------
// widths and counts
// ------------------------------------------------------------------
`define SARRD_RES_BITS        16
`define SARRD_CNT_W           5
`define SARRD_LAST_PLAIN      5'h10
`define SARRD_LAST_BUSY       5'h11
`define SARRD_FIFO_DEPTH      16
`define SARRD_FIFO_AW         4

// ------------------------------------------------------------------
// conversion timing
// ------------------------------------------------------------------
`define SARRD_CLK_PERIOD_PS   5000
`define SARRD_CONV_TIME_PS    500000
`define SARRD_CONV_CYCLES     ((`SARRD_CONV_TIME_PS) / (`SARRD_CLK_PERIOD_PS))
`define SARRD_CONV_CNT_W      8
`define SARRD_CONV_DIV        2

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define SARRD_RST_WORD        16'h0000

`endif

//--- src/sarrd_fifo.v
// sarrd_fifo.v: small synchronous fifo for conversion results
// assumes one clock, synchronous active high reset
`timescale 1ns/1ps
`include "sarrd_consts.vh"

module sarrd_fifo #(
    parameter WIDTH = `SARRD_RES_BITS,
    parameter DEPTH = `SARRD_FIFO_DEPTH,
    parameter AW    = `SARRD_FIFO_AW
) (
    input  wire             ref_clk,   // system clock
    input  wire             reset,     // sync reset, high
    input  wire             inValid,   // write request
    output wire             inReady,   // room available
    input  wire [WIDTH-1:0] inData,    // write word
    output wire             outValid,  // word available
    input  wire             outReady,  // consumer takes word
    output reg  [WIDTH-1:0] outData    // head word
);

    reg  [WIDTH-1:0] memArr [0:DEPTH-1];
    reg  [AW:0]      wrPtr_ff;
    reg  [AW:0]      rdPtr_ff;
    wire             full;
    wire             empty;
    wire             doWr;
    wire             doRd;

    // ------------------------------------------------------------------
    // flags
    // ------------------------------------------------------------------
    assign full     = (wrPtr_ff[AW] != rdPtr_ff[AW]) &&
                      (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]);
    assign empty    = (wrPtr_ff == rdPtr_ff);
    assign inReady  = !full;
    assign outValid = !empty;
    assign doWr     = inValid && !full;
    assign doRd     = outReady && !empty;

    // storage and pointers
    always @(posedge ref_clk) begin
        if (reset) begin
            wrPtr_ff <= {(AW+1){1'b0}};
            rdPtr_ff <= {(AW+1){1'b0}};
        end else begin
            if (doWr) begin
                wrPtr_ff <= wrPtr_ff + 1'b1;
            end
            if (doRd) begin
                rdPtr_ff <= rdPtr_ff + 1'b1;
            end
        end
        if (doWr) begin
            memArr[wrPtr_ff[AW-1:0]] <= inData;
        end
    end

    // head word from memory
    always @* begin
        outData = memArr[rdPtr_ff[AW-1:0]];
    end

endmodule // sarrd_fifo

//--- bench/sarrd_readout_asserts.sv
// checker of the readout controller port behaviour
// assumes a bind onto sarrd_readout, one clock domain
`timescale 1ns/1ps
module sarrd_readout_asserts #(
    parameter CONV_CYCLES = 4
) (
    input wire ref_clk,            // system clock
    input wire reset,              // sync reset
    input wire convert_start,      // convert pin
    input wire select_chain_input, // select pin
    input wire serial_shift_clock, // shift clock pin
    input wire serial_result_out,  // serial data
    input wire serial_result_oe,   // output enable
    input wire convBusy,           // converting
    input wire poweredDown,        // core off
    input wire chainMode,          // latched mode
    input wire sampleReady,        // start pulse
    input wire busyEnabled         // busy option
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // port relations
    // ------------------------------------------------------------
    AST_PWR: assert property ($fell(convBusy) |-> poweredDown[*3])
        else $error("core awake after conversion");
    AST_START: assert property (sampleReady |=> convBusy && !poweredDown)
        else $error("no conversion after start pulse");
    AST_CONVLEN: assert property ($rose(convBusy) |-> convBusy[*4] ##[1:40] !convBusy)
        else $error("conversion length wrong");
    AST_NOOE_CONV: assert property (convBusy && $past(convBusy) |-> !serial_result_oe)
        else $error("output driven during conversion");
    AST_MODE_HOLD: assert property (convBusy && $past(convBusy) |-> $stable(chainMode))
        else $error("mode changed during conversion");
    AST_OE_DONE: assert property ($fell(convBusy) ##1 (busyEnabled || chainMode)
        |-> ##[0:2] serial_result_oe)
        else $error("output not driven at conversion end");
    AST_BOTHLOW: assert property ((!convert_start && !select_chain_input && !convBusy)[*6]
        |-> serial_result_oe && !serial_result_out)
        else $error("both pins low but output not driven low");
    AST_REL_CNV: assert property ($rose(convert_start) ##1 convert_start[*5]
        |-> !serial_result_oe)
        else $error("output kept after convert rise");
    AST_REL_SEL: assert property (($rose(select_chain_input) && convert_start && !chainMode)
        ##1 (select_chain_input && convert_start)[*5] |-> !serial_result_oe)
        else $error("output kept after select rise");
    AST_BITHOLD: assert property ($rose(serial_shift_clock) && !convBusy && serial_result_oe
        |-> ##1 $stable(serial_result_out)[*8])
        else $error("bit changed while shift clock high");
    // main scenarios reached
    cover property (chainMode && busyEnabled && serial_result_oe);
    cover property (!chainMode && busyEnabled && $rose(serial_result_oe));
    cover property ($rose(select_chain_input) && convert_start && !chainMode);
endmodule // sarrd_readout_asserts

bind sarrd_readout sarrd_readout_asserts #(.CONV_CYCLES(CONV_CYCLES)) sarrd_chk_inst (
    .ref_clk(ref_clk), .reset(reset), .convert_start(convert_start),
    .select_chain_input(select_chain_input), .serial_shift_clock(serial_shift_clock),
    .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
    .convBusy(convBusy), .poweredDown(poweredDown), .chainMode(chainMode),
    .busyEnabled(busyEnabled), .sampleReady(sampleReady));

//--- bench/sarrd_host.sv
// host model: shift clock, upstream chain data, line capture
// assumes calls from the bench just after a falling ref_clk edge
`timescale 1ns/1ps
module sarrd_host (
    input  wire logic ref_clk,  // system clock
    input  wire logic sdoData,  // device data
    input  wire logic sdoOe,    // device drives line
    output logic      sckPin,   // shift clock, level outside frames set by setClk
    output logic      chainIn   // upstream chain bit
);
    logic lastBit_ff;
    initial begin
        sckPin = 1'b0;
        chainIn = 1'b0;
        lastBit_ff = 1'b0;
    end
    // released line shows the inverse of the last driven bit
    always @(posedge ref_clk) begin
        if (sdoOe) lastBit_ff <= sdoData;
    end
    task automatic setClk(input logic v);
        sckPin = v;
    endtask
    // 80 ns clock, bit taken just before each fall
    task automatic shift(input int n, input logic [15:0] feed, output logic [31:0] got);
        got = '0;
        chainIn = feed[15];
        for (int i = 0; i < n; i++) begin
            sckPin = 1'b1;
            repeat (8) @(negedge ref_clk);
            got = {got[30:0], sdoOe ? sdoData : ~lastBit_ff};
            sckPin = 1'b0;
            repeat (4) @(negedge ref_clk);
            chainIn = feed[15 - ((i + 1) % 16)];
            repeat (4) @(negedge ref_clk);
        end
    endtask
endmodule // sarrd_host

//--- bench/tb_top.sv
// self-checking bench of the readout controller
// assumes sarrd_host as far side and the bound checker
`timescale 1ns/1ps
module tb_top;
    logic        ref_clk, reset, cnvDrv, selDrv, useChain, resultReady;
    logic [15:0] sampleCode, lfsrState, upWord, exp16;
    logic [31:0] got;
    wire         sck, chainIn, sdo, sdoOe, convBusy, chainMode, busyEnabled, resultValid;
    wire  [15:0] resultData;
    wire         selPin;
    int          miscompares, samples_checked;
    logic [15:0] codeQ[$];
    assign selPin = useChain ? chainIn : selDrv;
    sarrd_readout #(.CONV_CYCLES(4)) sarrd_readout_inst (
        .ref_clk(ref_clk), .reset(reset), .convert_start(cnvDrv),
        .select_chain_input(selPin), .serial_shift_clock(sck), .serial_result_out(sdo),
        .serial_result_oe(sdoOe), .sampleCode(sampleCode), .sampleReady(),
        .convBusy(convBusy), .poweredDown(), .chainMode(chainMode),
        .busyEnabled(busyEnabled), .resultValid(resultValid),
        .resultReady(resultReady), .resultData(resultData));
    sarrd_host sarrd_host_inst (.ref_clk(ref_clk), .sdoData(sdo), .sdoOe(sdoOe),
        .sckPin(sck), .chainIn(chainIn));
    // 200 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    function automatic logic [15:0] lfsrNext(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chkBit(input string name, input logic exp, input logic seen);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %b seen %b", name, exp, seen);
        end
    endtask
    task automatic chkWord(input string name, input logic [15:0] exp, input logic [15:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic waitBusy(input logic lvl);
        for (int k = 0; k < 200 && convBusy !== lvl; k++) cyc(1);
        chkBit("convBusy", lvl, convBusy);
    endtask
    // one conversion and readout; m picks wiring and busy option
    task automatic conv(input int m);
        logic bz;
        int   n;
        bz = (m == 1 || m == 3 || m == 5);
        lfsrState = lfsrNext(lfsrState);
        sampleCode = lfsrState;
        lfsrState = lfsrNext(lfsrState);
        upWord = lfsrState;
        if (codeQ.size() < 16) codeQ.push_back(sampleCode);
        useChain = 1'b0;
        cnvDrv = 1'b0;
        selDrv = (m < 4);
        cyc(5);
        sarrd_host_inst.setClk(m == 5);
        cyc(5);
        cnvDrv = 1'b1;
        cyc(3);
        if (m <= 1) cnvDrv = 1'b0;
        if (m == 3) selDrv = 1'b0;
        cyc(2);
        if (m == 0) cnvDrv = 1'b1;
        waitBusy(1'b1);
        waitBusy(1'b0);
        cyc(3);
        chkBit("chainMode", m >= 4, chainMode);
        chkBit("busyEnabled", bz, busyEnabled);
        chkBit("outEnable", bz || m >= 4, sdoOe);
        if (m == 0) cnvDrv = 1'b0;
        if (m == 2) selDrv = 1'b0;
        if (m == 4) useChain = 1'b1;
        cyc(6);
        n = bz ? 17 : (m == 4 ? 32 : (m == 2 ? 8 : 16));
        sarrd_host_inst.shift(n, upWord, got);
        exp16 = m == 4 ? upWord : (m == 2 ? {8'h00, sampleCode[15:8]} : sampleCode);
        chkWord("resultWord", exp16, got[15:0]);
        if (m == 4) chkWord("chainWord", sampleCode, got[31:16]);
        if (m == 2) selDrv = 1'b1;
        cyc(6);
        chkBit("outEnable", m >= 4, sdoOe);
    endtask
    task automatic conclude();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        #200000;
        miscompares++;
        conclude();
    end
    // main sequence
    initial begin
        reset = 1'b1;
        cnvDrv = 1'b0;
        selDrv = 1'b0;
        useChain = 1'b0;
        resultReady = 1'b0;
        sampleCode = 16'h0000;
        lfsrState = 16'h0053;
        miscompares = 0;
        samples_checked = 0;
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        reset = 1'b0;
        cyc(8);
        chkBit("idleEnable", 1'b1, sdoOe);
        chkBit("idleLevel", 1'b0, sdo);
        for (int i = 0; i < 18; i++) conv(i % 6);
        for (int k = 0; k < 400 && codeQ.size() > 0; k++) begin
            @(negedge ref_clk);
            lfsrState = lfsrNext(lfsrState);
            resultReady = lfsrState[0];
            if (resultReady && resultValid) chkWord("fifoWord", codeQ.pop_front(), resultData);
        end
        cyc(1);
        chkWord("fifoLeft", 16'h0000, 16'(codeQ.size()));
        chkBit("fifoEmpty", 1'b0, resultValid);
        selDrv = 1'b0;
        cnvDrv = 1'b0;
        cyc(10);
        selDrv = 1'b1;
        cnvDrv = 1'b1;
        waitBusy(1'b1);
        waitBusy(1'b0);
        chkBit("tiedMode", 1'b1, chainMode);
        conclude();
    end
endmodule // tb_top
